// ==== rtl/ocl_pkg.sv ====
// package: register map, reset values and carriers of the limit slice
package ocl_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CFG      = 8'hC7;
    localparam logic [7:0] IDX_HIGH     = 8'hC8;
    localparam logic [7:0] IDX_LOW      = 8'hC9;
    localparam logic [7:0] IDX_FILL_A   = 8'hCA;
    localparam logic [7:0] IDX_FILL_B   = 8'hCB;
    localparam logic [7:0] IDX_FILL_C   = 8'hCC;
    localparam logic [7:0] IDX_FILL_D   = 8'hCD;
    localparam logic [7:0] IDX_FILL_E   = 8'hCE;
    localparam logic [7:0] IDX_STATUS   = 8'hE0;
    localparam logic [7:0] IDX_MASK     = 8'hE1;
    // values after reset
    localparam logic [15:0] RST_CFG     = 16'h0000;
    localparam logic [15:0] RST_HIGH    = 16'h7FFF;
    localparam logic [15:0] RST_LOW     = 16'h8000;
    localparam logic [15:0] RST_FILL_A  = 16'h5555;
    localparam logic [15:0] RST_FILL_B  = 16'h0010;
    localparam logic [15:0] RST_FILL_C  = 16'h0000;
    localparam logic [15:0] RST_FILL_D  = 16'h0000;
    localparam logic [15:0] RST_FILL_E  = 16'h0000;
    localparam logic [1:0]  RST_EVT     = 2'h0;
    // writable bits of each register
    localparam logic [15:0] WM_CFG      = 16'hFF00;
    localparam logic [15:0] WM_FULL     = 16'hFFFF;
    localparam logic [15:0] WM_FILL_B   = 16'h07F0;
    localparam logic [15:0] WM_FILL_C   = 16'hC703;
    localparam logic [15:0] WM_FILL_D   = 16'h00FF;
    // extremes that switch a limit off
    localparam logic [15:0] POS_FULL    = 16'h7FFF;
    localparam logic [15:0] NEG_FULL    = 16'h8000;
    // event bit positions in status and mask
    localparam int          EV_UPPER    = 0;
    localparam int          EV_LOWER    = 1;
    localparam int          NUM_EV      = 2;
    // deglitch count width and table corners
    localparam int          CNT_W       = 8;
    localparam logic [4:0]  SEL_STEP2   = 5'h0A;
    localparam logic [4:0]  SEL_STEP8   = 5'h13;
    localparam logic [7:0]  BASE_STEP2  = 8'h0C;
    localparam logic [7:0]  BASE_STEP8  = 8'h20;

    // configuration word as stored
    typedef struct packed {
        logic       fast_compare_enable;
        logic       fault_pin_polarity;
        logic       spare_cfg;
        logic [4:0] deglitch_count_select;
        logic [7:0] zero;
    } ocl_cfg_t;

    // one fast-filter result
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ocl_sample_t;
endpackage

// ==== rtl/ocl_regs.sv ====
// overcurrent limit registers, deglitch comparators and spare storage
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

module ocl_regs
    import ocl_pkg::*;
#(
    parameter int ADR_W = 10
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // fast-filter result, same clock
    input  wire ocl_sample_t      sample_i,
    // fault and interrupt outputs
    output logic                  upper_limit_event_o,
    output logic                  lower_limit_event_o,
    output logic                  fault_pin_o,
    output logic                  irq_o
);

    // register storage
    ocl_cfg_t           cfg;
    logic [15:0]        upper_limit_value;
    logic [15:0]        lower_limit_value;
    logic [15:0]        crc_filler_a;
    logic [15:0]        crc_filler_b;
    logic [15:0]        crc_filler_c;
    logic [15:0]        crc_filler_d;
    logic [15:0]        crc_filler_e;
    logic [NUM_EV-1:0]  ev_status;
    logic [NUM_EV-1:0]  ev_mask;

    // bus decode
    logic               bus_req;
    logic               wr_now;
    logic [7:0]         idx;
    logic [15:0]        next_rdata;

    // comparator state
    logic [NUM_EV-1:0]  evt;
    logic [NUM_EV-1:0]  evt_q;
    logic [NUM_EV-1:0]  evt_rise;
    logic [CNT_W-1:0]   need;
    logic               any_evt;

    assign bus_req = wb_cyc_i & wb_stb_i;
    assign idx     = wb_adr_i[9:2];
    // write lands on the edge where the master sees ack
    assign wr_now  = bus_req & wb_we_i & wb_ack_o;
    assign any_evt = |evt;

    // byte-lane merge of a write, keeping read-only bits zero
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel,
        input logic [15:0] wm
    );
        logic [15:0] res;
        res = old;
        if (sel[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res & wm;
    endfunction

    // conversions needed before a trip, from the select code
    function automatic logic [CNT_W-1:0] count_need(
        input logic [4:0] sel
    );
        logic [CNT_W-1:0] s;
        s = {3'h0, sel};
        if (sel < SEL_STEP2)
        begin
            return s + 8'h01;
        end
        else if (sel < SEL_STEP8)
        begin
            return BASE_STEP2 + ((s - {3'h0, SEL_STEP2}) << 1);
        end
        else
        begin
            return BASE_STEP8 + ((s - {3'h0, SEL_STEP8}) << 3);
        end
    endfunction

    assign need = count_need(cfg.deglitch_count_select);

    // ack one cycle per request; unmapped addresses ack too
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // read mux; unmapped and upper bits read zero
    always_comb
    begin
        next_rdata = 16'h0000;
        if (idx == IDX_CFG)
        begin
            next_rdata = cfg;
        end
        else if (idx == IDX_HIGH)
        begin
            next_rdata = upper_limit_value;
        end
        else if (idx == IDX_LOW)
        begin
            next_rdata = lower_limit_value;
        end
        else if (idx == IDX_FILL_A)
        begin
            next_rdata = crc_filler_a;
        end
        else if (idx == IDX_FILL_B)
        begin
            next_rdata = crc_filler_b;
        end
        else if (idx == IDX_FILL_C)
        begin
            next_rdata = crc_filler_c;
        end
        else if (idx == IDX_FILL_D)
        begin
            next_rdata = crc_filler_d;
        end
        else if (idx == IDX_FILL_E)
        begin
            next_rdata = crc_filler_e;
        end
        else if (idx == IDX_STATUS)
        begin
            next_rdata = {14'h0000, ev_status};
        end
        else if (idx == IDX_MASK)
        begin
            next_rdata = {14'h0000, ev_mask};
        end
    end

    // read data registered together with ack
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req & ~wb_ack_o)
        begin
            wb_dat_o <= {16'h0000, next_rdata};
        end
    end

    // limits; compare logic reads them live, so a write
    // takes hold for the next result after the ack edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            upper_limit_value <= RST_HIGH;
            lower_limit_value <= RST_LOW;
        end
        else if (wr_now)
        begin
            if (idx == IDX_HIGH)
            begin
                upper_limit_value <= lane_merge(upper_limit_value,
                    wb_dat_i, wb_sel_i, WM_FULL);
            end
            else if (idx == IDX_LOW)
            begin
                lower_limit_value <= lane_merge(lower_limit_value,
                    wb_dat_i, wb_sel_i, WM_FULL);
            end
        end
    end

    // configuration word
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cfg <= ocl_cfg_t'(RST_CFG);
        end
        else if (wr_now && idx == IDX_CFG)
        begin
            cfg <= ocl_cfg_t'(lane_merge(cfg, wb_dat_i,
                wb_sel_i, WM_CFG));
        end
    end

    // spare storage: nothing else in the block reads it
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            crc_filler_a <= RST_FILL_A;
            crc_filler_b <= RST_FILL_B;
            crc_filler_c <= RST_FILL_C;
            crc_filler_d <= RST_FILL_D;
            crc_filler_e <= RST_FILL_E;
        end
        else if (wr_now)
        begin
            if (idx == IDX_FILL_A)
            begin
                crc_filler_a <= lane_merge(crc_filler_a,
                    wb_dat_i, wb_sel_i, WM_FULL);
            end
            else if (idx == IDX_FILL_B)
            begin
                crc_filler_b <= lane_merge(crc_filler_b,
                    wb_dat_i, wb_sel_i, WM_FILL_B);
            end
            else if (idx == IDX_FILL_C)
            begin
                crc_filler_c <= lane_merge(crc_filler_c,
                    wb_dat_i, wb_sel_i, WM_FILL_C);
            end
            else if (idx == IDX_FILL_D)
            begin
                crc_filler_d <= lane_merge(crc_filler_d,
                    wb_dat_i, wb_sel_i, WM_FILL_D);
            end
            else if (idx == IDX_FILL_E)
            begin
                crc_filler_e <= lane_merge(crc_filler_e,
                    wb_dat_i, wb_sel_i, WM_FULL);
            end
        end
    end

    // one deglitching comparator per direction
    genvar g;
    generate
        for (g = 0; g < NUM_EV; g++)
        begin : g_cmp
            logic             beyond;
            logic             off;
            logic [CNT_W-1:0] cnt;
            logic [CNT_W:0]   cnt_inc;

            // signed compare, same scale as the result
            if (g == EV_UPPER)
            begin : g_up
                assign beyond = $signed(sample_i.data)
                    > $signed(upper_limit_value);
                assign off = upper_limit_value == POS_FULL;
            end
            else
            begin : g_lo
                assign beyond = $signed(sample_i.data)
                    < $signed(lower_limit_value);
                assign off = lower_limit_value == NEG_FULL;
            end
            assign cnt_inc = {1'b0, cnt} + 9'h001;

            // saturating run length; no hysteresis on release
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    cnt    <= '0;
                    evt[g] <= 1'b0;
                end
                else if (!cfg.fast_compare_enable)
                begin
                    cnt    <= '0;
                    evt[g] <= 1'b0;
                end
                else if (sample_i.valid)
                begin
                    if (beyond && !off)
                    begin
                        if (cnt_inc >= {1'b0, need})
                        begin
                            cnt    <= need;
                            evt[g] <= 1'b1;
                        end
                        else
                        begin
                            cnt    <= cnt_inc[CNT_W-1:0];
                        end
                    end
                    else
                    begin
                        cnt    <= '0;
                        evt[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign evt_rise = evt & ~evt_q;

    // sticky status, write one to clear; a new event wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            evt_q     <= RST_EVT;
            ev_status <= RST_EVT;
            ev_mask   <= RST_EVT;
        end
        else
        begin
            evt_q <= evt;
            if (wr_now && idx == IDX_STATUS && wb_sel_i[0])
            begin
                ev_status <= (ev_status & ~wb_dat_i[NUM_EV-1:0])
                    | evt_rise;
            end
            else
            begin
                ev_status <= ev_status | evt_rise;
            end
            if (wr_now && idx == IDX_MASK && wb_sel_i[0])
            begin
                ev_mask <= wb_dat_i[NUM_EV-1:0];
            end
        end
    end

    // pin, event and interrupt outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            fault_pin_o         <= 1'b1; // idle level of polarity 0
            upper_limit_event_o <= 1'b0;
            lower_limit_event_o <= 1'b0;
            irq_o               <= 1'b0;
        end
        else
        begin
            fault_pin_o <= cfg.fault_pin_polarity
                ? any_evt : ~any_evt;
            upper_limit_event_o <= evt[EV_UPPER];
            lower_limit_event_o <= evt[EV_LOWER];
            irq_o <= |(ev_status & ev_mask);
        end
    end

    // checks beside the logic
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_wr_fill_b;
        wr_now && idx == IDX_FILL_B;
    endsequence

    a_ack_single: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");

    a_reset_values: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        $rose(rst_n_i) |-> upper_limit_value == 16'h7FFF
            && lower_limit_value == 16'h8000
            && crc_filler_a == 16'h5555
            && crc_filler_b == 16'h0010)
        else $error("limit or spare reset value wrong");

    a_high_trip: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        sample_i.valid && cfg.fast_compare_enable
            && cfg.deglitch_count_select == 5'h00
            && $signed(sample_i.data) > $signed(upper_limit_value)
            && upper_limit_value != 16'h7FFF
        |=> evt[EV_UPPER] ##1 upper_limit_event_o)
        else $error("upper event missing after exceedance");

    a_high_disable: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        sample_i.valid && upper_limit_value == 16'h7FFF
        |=> !evt[EV_UPPER])
        else $error("upper event with limit at full scale");

    a_low_disable: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        sample_i.valid && lower_limit_value == 16'h8000
        |=> !evt[EV_LOWER])
        else $error("lower event with limit at full scale");

    a_count_restart: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        sample_i.valid
            && $signed(sample_i.data) >= $signed(lower_limit_value)
        |=> !evt[EV_LOWER] && g_cmp[EV_LOWER].cnt == 8'h00)
        else $error("lower count not restarted");

    a_enable_off: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !cfg.fast_compare_enable [*2] |-> evt == 2'b00
            ##1 !upper_limit_event_o && !lower_limit_event_o)
        else $error("event while comparator disabled");

    a_fault_pin: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        ##1 1'b1 |-> fault_pin_o
            == ($past(cfg.fault_pin_polarity) ~^ $past(any_evt)))
        else $error("fault pin level wrong");

    a_spare_write: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        s_wr_fill_b and (wb_sel_i[1:0] == 2'b11)
        |=> crc_filler_b == ($past(wb_dat_i[15:0]) & 16'h07F0)
            && $stable(upper_limit_value))
        else $error("spare write stored wrongly");

endmodule

`default_nettype wire

// ==== sim/ocl_regs_bench.sv ====
// self-checking bench of the overcurrent limit register slice
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) check(32'(g), 32'(e))

module ocl_regs_bench
    import ocl_pkg::*;
;
    // one register access and the word it should read back
    typedef struct packed {
        logic        we;
        logic [7:0]  idx;
        logic [15:0] wd;
        logic [15:0] exp;
    } ocl_row_t;

    localparam ocl_row_t ROWS [16] = '{
        '{1'b0, IDX_HIGH, 16'h0000, 16'h7FFF},
        '{1'b0, IDX_LOW, 16'h0000, 16'h8000},
        '{1'b0, IDX_FILL_A, 16'h0000, 16'h5555},
        '{1'b0, IDX_FILL_B, 16'h0000, 16'h0010},
        '{1'b0, IDX_FILL_C, 16'h0000, 16'h0000},
        '{1'b0, IDX_FILL_D, 16'h0000, 16'h0000},
        '{1'b0, IDX_FILL_E, 16'h0000, 16'h0000},
        '{1'b0, 8'hD0, 16'h0000, 16'h0000},
        '{1'b1, IDX_HIGH, 16'h8001, 16'h8001},
        '{1'b1, IDX_LOW, 16'h7FFE, 16'h7FFE},
        '{1'b1, IDX_FILL_A, 16'hAAAA, 16'hAAAA},
        '{1'b1, IDX_FILL_B, 16'hFFFF, 16'h07F0},
        '{1'b1, IDX_FILL_C, 16'hFFFF, 16'hC703},
        '{1'b1, IDX_FILL_D, 16'hFFFF, 16'h00FF},
        '{1'b1, IDX_FILL_E, 16'hFFFF, 16'hFFFF},
        '{1'b1, 8'hD0, 16'hFFFF, 16'h0000}
    };
    localparam logic [4:0] CODES [3] = '{5'h02, 5'h0A, 5'h13};
    localparam int         COUNTS [3] = '{3, 12, 32};

    // design ports
    logic             clk_i;
    logic             rst_n_i;
    logic             wb_cyc_i;
    logic             wb_stb_i;
    logic             wb_we_i;
    logic [9:0]       wb_adr_i;
    logic [3:0]       wb_sel_i;
    logic [31:0]      wb_dat_i;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    ocl_sample_t      sample_i;
    logic             upper_limit_event_o;
    logic             lower_limit_event_o;
    logic             fault_pin_o;
    logic             irq_o;
    // bench state
    int               n_errors = 0;
    int               compares = 0;
    logic             pol = 1'b0;
    logic [31:0]      rd;

    ocl_regs #(.ADR_W(10)) i_dut (
        .clk_i               (clk_i),
        .rst_n_i             (rst_n_i),
        .wb_cyc_i            (wb_cyc_i),
        .wb_stb_i            (wb_stb_i),
        .wb_we_i             (wb_we_i),
        .wb_adr_i            (wb_adr_i),
        .wb_sel_i            (wb_sel_i),
        .wb_dat_i            (wb_dat_i),
        .wb_dat_o            (wb_dat_o),
        .wb_ack_o            (wb_ack_o),
        .sample_i            (sample_i),
        .upper_limit_event_o (upper_limit_event_o),
        .lower_limit_event_o (lower_limit_event_o),
        .fault_pin_o         (fault_pin_o),
        .irq_o               (irq_o)
    );

    // 125 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // classic single cycle; waits for ack with a bounded count
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [15:0] d, input logic [3:0] sel,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50)
            `CHK(1'b0, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'h3, q);
    endtask

    // one valid result, then the event outputs two edges after it
    task automatic smp(input logic [15:0] d, input logic up,
                       input logic lo);
        @(posedge clk_i);
        sample_i <= {1'b1, d};
        @(posedge clk_i);
        sample_i.valid <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(upper_limit_event_o, up);
        `CHK(lower_limit_event_o, lo);
        `CHK(fault_pin_o, pol ? (up | lo) : !(up | lo));
    endtask

    task automatic do_reset;
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        pol = 1'b0;
        `CHK({wb_ack_o, upper_limit_event_o, lower_limit_event_o}, 0);
        `CHK({irq_o, fault_pin_o}, 2'b01);
    endtask

    // hang guard, far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

    initial
    begin
        rst_n_i  = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = '0;
        sample_i = '0;
        do_reset();
        // reset values, access kinds, unmapped place
        for (int i = 0; i < 16; i++)
        begin
            if (ROWS[i].we)
                wb(1'b1, ROWS[i].idx, ROWS[i].wd, 4'hF, rd);
            wb(1'b0, ROWS[i].idx, 16'h0000, 4'hF, rd);
            `CHK(rd, {16'h0000, ROWS[i].exp});
        end
        // low lane only
        wb(1'b1, IDX_HIGH, 16'h1234, 4'h1, rd);
        wb(1'b0, IDX_HIGH, 16'h0000, 4'hF, rd);
        `CHK(rd, 32'h0000_8034);
        wr(IDX_HIGH, 16'h7FFF);
        wr(IDX_LOW, 16'h8000);
        wr(IDX_CFG, 16'h8000);
        // extremes never trip
        smp(16'h7FFF, 1'b0, 1'b0);
        smp(16'h8000, 1'b0, 1'b0);
        // new limit takes effect on the very next result
        wr(IDX_HIGH, 16'h0100);
        smp(16'h0101, 1'b1, 1'b0);
        smp(16'h0100, 1'b0, 1'b0);
        wr(IDX_LOW, 16'hFF00);
        smp(16'hFEFF, 1'b0, 1'b1);
        smp(16'hFF00, 1'b0, 1'b0);
        // active-high fault pin
        wr(IDX_CFG, 16'hC000);
        pol = 1'b1;
        smp(16'h8001, 1'b0, 1'b1);
        smp(16'h0000, 1'b0, 1'b0);
        // sticky status, mask and clear
        wr(IDX_MASK, 16'h0003);
        wb(1'b0, IDX_STATUS, 16'h0000, 4'hF, rd);
        `CHK(rd, 32'h0000_0003);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b1);
        wr(IDX_STATUS, 16'h0003);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0);
        smp(16'h0200, 1'b1, 1'b0);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b1);
        wr(IDX_MASK, 16'h0000);
        @(posedge clk_i);
        #1;
        `CHK(irq_o, 1'b0);
        // spare write leaves a standing event alone
        wr(IDX_FILL_E, 16'h0000);
        `CHK(upper_limit_event_o, 1'b1);
        smp(16'h0000, 1'b0, 1'b0);
        // deglitch counts with a restart in mid-run
        pol = 1'b0;
        for (int c = 0; c < 3; c++)
        begin
            wr(IDX_CFG, {3'b100, CODES[c], 8'h00});
            for (int k = 1; k < COUNTS[c]; k++)
                smp(16'h0200, 1'b0, 1'b0);
            smp(16'h0050, 1'b0, 1'b0);
            for (int k = 1; k < COUNTS[c]; k++)
                smp(16'h0200, 1'b0, 1'b0);
            smp(16'h0200, 1'b1, 1'b0);
            smp(16'h0050, 1'b0, 1'b0);
        end
        // disabling clears the event and ignores results
        wr(IDX_CFG, 16'h8000);
        smp(16'h0200, 1'b1, 1'b0);
        wr(IDX_CFG, 16'h0000);
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(upper_limit_event_o, 1'b0);
        smp(16'h0200, 1'b0, 1'b0);
        // second reset in mid-run; config low byte reads zero
        wr(IDX_CFG, 16'hFFFF);
        wb(1'b0, IDX_CFG, 16'h0000, 4'hF, rd);
        `CHK(rd, 32'h0000_FF00);
        do_reset();
        wb(1'b0, IDX_HIGH, 16'h0000, 4'hF, rd);
        `CHK(rd, 32'h0000_7FFF);
        wb(1'b0, IDX_LOW, 16'h0000, 4'hF, rd);
        `CHK(rd, 32'h0000_8000);
        test_done();
    end
endmodule

`default_nettype wire
